/* File: middle_speed_auto_switch.sv */
// Clock-mode control: stop-release reload, automatic low-to-middle switch, related registers
`timescale 1ns/10ps
module middle_speed_auto_switch #(
   parameter bit HAS_I2C = 1'b1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // Stop release and pins
   input wire logic stop_release_ext_i,
   input wire logic scl_pin_i,
   input wire logic sda_pin_i,
   // Timer and prescaler reload
   output logic reload_o,
   output logic [7:0] reload_timer_o,
   output logic [7:0] reload_prescaler_o,
   // Clock control
   output logic main_osc_en_o,
   output logic [1:0] clock_mode_o,
   output logic [7:0] irq_enable_o,
   output logic [4:0] condition_timing_count_o,
   output logic [5:0] release_cycles_o,
   output logic [4:0] setup_hold_half_o,
   // Interrupt
   output logic irq_o
);
   import clock_switch_pkg::*;

   // Overview of the block
   // Single clock domain; no derived clocks
   // Machine cycle is an enable pulse, not a clock
   // Register port has no wait states
   // Read data stands one cycle, zero otherwise
   //
   // Stop release path
   // Release pulse arrives already in this clock domain
   // Reload pulse follows the release by one cycle
   // Reload values are fixed constants
   // Timer side latches the values on the pulse
   // With reload inhibited, timer keeps its own values
   // So software must preload before halting
   //
   // Automatic switch path
   // Two triggers: register write or pin edge
   // Both need the CPU mode field at low speed
   // Program trigger is the write strobe itself
   // Start bit is never stored; it reads back zero
   // Pin trigger also needs the enable bit
   // Pin trigger uses the filtered chosen pin
   // Polarity bit picks falling or rising edge
   // Choice bit picks data or clock pin
   //
   // Sequencer
   // Idle: waits for a trigger
   // Wait: oscillator requested, counting machine cycles
   // Done: one cycle, writes the middle-speed code
   // Triggers during wait or done are dropped
   // One switch at a time keeps the count simple
   //
   // Wait length
   // Count uses the lower figure of each range
   // Divider restarts on entry, so it adds no phase
   // So the real wait stays inside the range
   // Longer wait suits slow-starting crystals
   //
   // Pin filter
   // Three flops; later two must agree
   // Disagreement holds the previous level
   // Costs three cycles of latency on edges
   // Trades latency for glitch rejection
   // Choice change with unequal pins fakes an edge
   // Software should change choice with auto switch off
   //
   // Condition timing outputs
   // Release count is field plus one
   // Setup and hold count is half of that
   // Half is truncated; engine rounds the odd case
   // Outputs are registered copies, one cycle behind
   //
   // Event status and interrupt
   // Three sticky bits: switched, reloaded, pin edge
   // Write one to clear each bit
   // A new event in the clearing cycle survives
   // Mask has the same layout
   // Interrupt is a registered level
   //
   // Variant without the I2C unit
   // Condition register reads zero, ignores writes
   // Pin trigger then uses the reset settings: data pin, falling edge
   // I2C-only enable bits stay zero
   //
   // Known limits
   // No debounce beyond the three flops
   // No abort of a switch once started
   // Software write to mode field loses to completion

   logic [7:0] misc_clock_switch_control;
   logic [7:0] start_stop_condition_control;
   logic [7:0] interrupt_enable_first;
   logic [7:0] cpu_mode;
   logic [EVT_BITS-1:0] evt_status;
   logic [EVT_BITS-1:0] evt_mask;
   logic [2:0] scl_sync;
   logic [2:0] sda_sync;
   logic pin_prev;
   logic pin_now;
   logic pin_edge;
   logic [1:0] mc_count;
   logic mc_tick;
   logic [3:0] wait_count;
   switch_state_type state;
   logic low_speed;
   logic start_by_program;
   logic start_by_pin;
   logic switch_done;
   logic reload_now;
   logic [7:0] next_rdata;
   logic [EVT_BITS-1:0] evt_set;
   logic sel_misc;
   logic sel_ssc;
   logic sel_cpu;
   logic sel_irq;

   // Address decode; the condition register is absent without I2C
   assign sel_misc = (addr_i == ADDR_MISC_CLOCK);
   assign sel_ssc = HAS_I2C && (addr_i == ADDR_START_STOP);
   assign sel_cpu = (addr_i == ADDR_CPU_MODE);
   assign sel_irq = (addr_i == ADDR_IRQ_ENABLE);

   // Pin synchronisers, three stages; second and third must agree
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_pin_i};
         sda_sync <= {sda_sync[1:0], sda_pin_i};
      end
   end

   always_comb begin
      if (start_stop_condition_control[SSC_PIN_CHOICE]) begin
         pin_now = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : pin_prev;
      end else begin
         pin_now = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : pin_prev;
      end
   end

   // Filtered level of the chosen pin; a change in pin choice may fake one edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_prev <= 1'b1;
      end else begin
         pin_prev <= pin_now;
      end
   end

   assign pin_edge = start_stop_condition_control[SSC_POLARITY] ? (pin_now && !pin_prev)
                                                                 : (!pin_now && pin_prev);

   assign low_speed = (cpu_mode[CPU_MODE_MSB:CPU_MODE_LSB] == MODE_LOW);
   assign start_by_program = wr_i && sel_misc && wdata_i[MISC_START] && low_speed;
   assign start_by_pin = misc_clock_switch_control[MISC_AUTO_EN] && pin_edge && low_speed;
   assign switch_done = (state == ST_WAIT) && mc_tick && (wait_count == 4'h0);

   // Machine cycle divider, runs only while waiting so the wait has no phase error
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mc_count <= 2'h0;
      end else if (state != ST_WAIT || mc_count == MC_DIV_LAST) begin
         mc_count <= 2'h0;
      end else begin
         mc_count <= mc_count + 2'h1;
      end
   end
   assign mc_tick = (state == ST_WAIT) && (mc_count == MC_DIV_LAST);

   // Switch sequencer: start oscillator, wait, then change mode
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         wait_count <= 4'h0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start_by_program || start_by_pin) begin
                  state <= ST_WAIT;
                  wait_count <= misc_clock_switch_control[MISC_LONG_WAIT] ?
                                WAIT_LONG - 4'h1 : WAIT_SHORT - 4'h1;
               end
            end
            ST_WAIT: begin
               if (switch_done) begin
                  state <= ST_DONE;
               end else if (mc_tick) begin
                  wait_count <= wait_count - 4'h1;
               end
            end
            ST_DONE: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Oscillator request follows the sequencer or any mode other than low speed
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         main_osc_en_o <= 1'b0;
      end else begin
         main_osc_en_o <= (state != ST_IDLE) || !low_speed;
      end
   end

   // Miscellaneous clock register; start bit is a trigger, not stored
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         misc_clock_switch_control <= 8'h00;
      end else if (wr_i && sel_misc) begin
         misc_clock_switch_control <= wdata_i & MISC_WRITE_MASK;
      end
   end

   // Start/stop condition control register
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         start_stop_condition_control <= SSC_RESET;
      end else if (wr_i && sel_ssc) begin
         start_stop_condition_control <= wdata_i & SSC_WRITE_MASK;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         condition_timing_count_o <= 5'h0;
         release_cycles_o <= 6'h1;
         setup_hold_half_o <= 5'h0;
      end else begin
         condition_timing_count_o <= start_stop_condition_control[SSC_MSB:SSC_LSB];
         release_cycles_o <= {1'b0, start_stop_condition_control[SSC_MSB:SSC_LSB]} + 6'h1;
         // Half of (field+1), truncated; the timing engine adds the half cycle
         setup_hold_half_o <= 5'(({1'b0, start_stop_condition_control[SSC_MSB:SSC_LSB]}
                                  + 6'h1) >> 1);
      end
   end

   // Interrupt enable register; I2C-only enables held at zero without I2C
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         interrupt_enable_first <= 8'h00;
      end else if (wr_i && sel_irq) begin
         interrupt_enable_first <= wdata_i &
            (HAS_I2C ? IRQ_EN_WRITE_MASK_I2C : IRQ_EN_WRITE_MASK_NO_I2C);
      end
   end

   // CPU mode register; a completed switch overrides a same-cycle write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cpu_mode <= CPU_MODE_RESET;
      end else if (state == ST_DONE) begin
         cpu_mode[CPU_MODE_MSB:CPU_MODE_LSB] <= MODE_MIDDLE;
      end else if (wr_i && sel_cpu) begin
         cpu_mode <= wdata_i;
      end
   end

   // Stop release reload
   assign reload_now = stop_release_ext_i && !misc_clock_switch_control[MISC_NO_RELOAD];
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reload_o <= 1'b0;
         reload_timer_o <= RELOAD_TIMER;
         reload_prescaler_o <= RELOAD_PRESCALER;
      end else begin
         reload_o <= reload_now;
         reload_timer_o <= RELOAD_TIMER;
         reload_prescaler_o <= RELOAD_PRESCALER;
      end
   end

   // Sticky events; set wins over write-one-to-clear
   assign evt_set = {pin_edge, reload_now, state == ST_DONE};
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_status <= '0;
         evt_mask <= '0;
      end else begin
         if (wr_i && addr_i == ADDR_EVT_STATUS) begin
            evt_status <= (evt_status & ~wdata_i[EVT_BITS-1:0]) | evt_set;
         end else begin
            evt_status <= evt_status | evt_set;
         end
         if (wr_i && addr_i == ADDR_EVT_MASK) begin
            evt_mask <= wdata_i[EVT_BITS-1:0];
         end
      end
   end

   // Registered outputs
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
         clock_mode_o <= CPU_MODE_RESET[CPU_MODE_MSB:CPU_MODE_LSB];
         irq_enable_o <= 8'h00;
      end else begin
         irq_o <= |(evt_status & evt_mask);
         clock_mode_o <= cpu_mode[CPU_MODE_MSB:CPU_MODE_LSB];
         irq_enable_o <= interrupt_enable_first;
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      next_rdata = 8'h00;
      if (sel_misc) begin
         next_rdata = misc_clock_switch_control;
      end else if (sel_ssc) begin
         next_rdata = start_stop_condition_control;
      end else if (sel_cpu) begin
         next_rdata = cpu_mode;
      end else if (sel_irq) begin
         next_rdata = interrupt_enable_first;
      end else if (addr_i == ADDR_EVT_STATUS) begin
         next_rdata = {5'h0, evt_status};
      end else if (addr_i == ADDR_EVT_MASK) begin
         next_rdata = {5'h0, evt_mask};
      end else if (addr_i == ADDR_MODE_STATUS) begin
         next_rdata = {5'h0, state};
      end
   end

   // Read data valid only the cycle after the strobe
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
      end else begin
         rdata_o <= rd_i ? next_rdata : 8'h00;
      end
   end
endmodule

/* File: clock_switch_pkg.sv */
// Package: register map, field positions, reset values and timing for the clock switch block
package clock_switch_pkg;
   // Register offsets (byte addresses on the plain register port)
   localparam logic [7:0] ADDR_START_STOP = 8'h30;
   localparam logic [7:0] ADDR_MISC_CLOCK = 8'h38;
   localparam logic [7:0] ADDR_CPU_MODE = 8'h3b;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h3e;
   localparam logic [7:0] ADDR_EVT_STATUS = 8'h40;
   localparam logic [7:0] ADDR_EVT_MASK = 8'h41;
   localparam logic [7:0] ADDR_MODE_STATUS = 8'h42;
   // Miscellaneous clock register fields
   localparam int MISC_NO_RELOAD = 0;
   localparam int MISC_AUTO_EN = 1;
   localparam int MISC_LONG_WAIT = 2;
   localparam int MISC_START = 3;
   localparam logic [7:0] MISC_WRITE_MASK = 8'h07;
   // Start/stop condition control fields
   localparam int SSC_LSB = 0;
   localparam int SSC_MSB = 4;
   localparam int SSC_POLARITY = 5;
   localparam int SSC_PIN_CHOICE = 6;
   localparam logic [7:0] SSC_WRITE_MASK = 8'h7f;
   localparam logic [7:0] SSC_RESET = 8'h00;
   // Interrupt enable register: bits 1 and 5 are the I2C-only enables
   localparam logic [7:0] IRQ_EN_WRITE_MASK_NO_I2C = 8'hdd;
   localparam logic [7:0] IRQ_EN_WRITE_MASK_I2C = 8'hff;
   // Stop-release reload values
   localparam logic [7:0] RELOAD_PRESCALER = 8'hff;
   localparam logic [7:0] RELOAD_TIMER = 8'h01;
   // CPU mode register clock field and codes
   localparam int CPU_MODE_LSB = 6;
   localparam int CPU_MODE_MSB = 7;
   localparam logic [1:0] MODE_MIDDLE = 2'h2;
   localparam logic [1:0] MODE_LOW = 2'h3;
   localparam logic [7:0] CPU_MODE_RESET = 8'h80;
   // Event status bits
   localparam int EVT_SWITCHED = 0;
   localparam int EVT_RELOADED = 1;
   localparam int EVT_PIN_EDGE = 2;
   localparam int EVT_BITS = 3;
   // Wait times in machine cycles (lower figure), one machine cycle per tick
   localparam int WAIT_SHORT_CYC = 5;
   localparam int WAIT_LONG_CYC = 7;
   localparam logic [3:0] WAIT_SHORT = 4'(WAIT_SHORT_CYC);
   localparam logic [3:0] WAIT_LONG = 4'(WAIT_LONG_CYC);
   // Machine cycle: 4 clocks of 25 ns = 100 ns
   localparam int MACHINE_CYCLE_NS = 100;
   localparam int CLK_PERIOD_NS = 25;
   localparam int MC_DIV = MACHINE_CYCLE_NS / CLK_PERIOD_NS;
   localparam logic [1:0] MC_DIV_LAST = 2'(MC_DIV - 1);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_DONE = 3'b100
   } switch_state_type;
endpackage

/* File: switch_props.sv */
// Port-level checks for the clock-mode switch block
`timescale 1ns/10ps
module switch_props
   import clock_switch_pkg::*;
(
   // Clock, reset and register port
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   // Stop release and clock control
   input wire logic stop_release_ext_i,
   input wire logic reload_o,
   input wire logic [7:0] reload_timer_o,
   input wire logic [7:0] reload_prescaler_o,
   input wire logic main_osc_en_o,
   input wire logic [1:0] clock_mode_o,
   input wire logic [7:0] irq_enable_o,
   input wire logic [4:0] condition_timing_count_o,
   input wire logic [5:0] release_cycles_o,
   input wire logic [4:0] setup_hold_half_o
);
   logic no_reload, auto_en;
   wire misc_wr = wr_i && addr_i == ADDR_MISC_CLOCK;
   // Shadow of misc bits, so checks need no body access
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         no_reload <= 1'b0;
         auto_en <= 1'b0;
      end else if (misc_wr) begin
         no_reload <= wdata_i[MISC_NO_RELOAD];
         auto_en <= wdata_i[MISC_AUTO_EN];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_reload_fires:
   assert property (stop_release_ext_i && !no_reload && !misc_wr |=> reload_o)
      else $error("reload pulse missing");
   a_timer_value:
   assert property (reload_o |-> reload_timer_o == RELOAD_TIMER)
      else $error("timer reload value wrong");
   a_reload_kept:
   assert property (stop_release_ext_i && no_reload && !misc_wr |=> !reload_o)
      else $error("reload not inhibited");
   a_no_auto_start:
   assert property (clock_mode_o == MODE_LOW && !main_osc_en_o && !auto_en && !wr_i &&
      !$past(wr_i)
      |=> !main_osc_en_o) else $error("switch started while disabled");
   a_short_wait:
   assert property (misc_wr && wdata_i[MISC_START] && !wdata_i[MISC_LONG_WAIT] &&
      clock_mode_o == MODE_LOW && !main_osc_en_o
      |-> ##16 clock_mode_o == MODE_LOW ##[1:9] clock_mode_o == MODE_MIDDLE)
      else $error("short wait switch timing wrong");
   a_long_wait:
   assert property (misc_wr && wdata_i[MISC_START] && wdata_i[MISC_LONG_WAIT] &&
      clock_mode_o == MODE_LOW && !main_osc_en_o
      |-> ##24 clock_mode_o == MODE_LOW ##[1:9] clock_mode_o == MODE_MIDDLE)
      else $error("long wait switch timing wrong");
   a_misc_upper_zero:
   assert property (rd_i && addr_i == ADDR_MISC_CLOCK |=> rdata_o[7:4] == 4'h0)
      else $error("misc upper bits not zero");
   a_release_time:
   assert property (release_cycles_o == 6'(condition_timing_count_o) + 6'h1 &&
      setup_hold_half_o == 5'((6'(condition_timing_count_o) + 6'h1) >> 1))
      else $error("release or setup time wrong");
   a_enable_copy:
   assert property (wr_i && addr_i == ADDR_IRQ_ENABLE |=> ##1 irq_enable_o == $past(wdata_i, 2))
      else $error("enable register copy wrong");
endmodule

/* File: tb.sv */
// Self-checking bench for the clock-mode switch block
`timescale 1ns/10ps
module tb;
   import clock_switch_pkg::*;
   // Stimulus and observed signals
   logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, stop_release_ext_i = 0;
   logic scl_pin_i = 1, sda_pin_i = 1, reload_o, main_osc_en_o, irq_o, q;
   logic [7:0] addr_i = 0, wdata_i = 0, rdata_o, d, v;
   logic [7:0] reload_timer_o, reload_prescaler_o, irq_enable_o;
   logic [1:0] clock_mode_o;
   logic [4:0] condition_timing_count_o, setup_hold_half_o;
   logic [5:0] release_cycles_o;
   logic [7:0] ra[5] = '{ADDR_MISC_CLOCK, ADDR_START_STOP, ADDR_IRQ_ENABLE, ADDR_CPU_MODE, 8'h55};
   logic [7:0] rv[5] = '{8'h00, SSC_RESET, 8'h00, CPU_MODE_RESET, 8'h00};
   int errors = 0, num_checks = 0, seed = 42, n, lo;
   // 25 ns clock
   always #12.5 clk_i = ~clk_i;
   middle_speed_auto_switch DUT (.*);
   // Compare and count
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Register port cycles; one idle cycle after each strobe
   task automatic wr(logic [7:0] a, logic [7:0] x);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= x;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, output logic [7:0] x);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      x = rdata_o;
   endtask
   task automatic wait_mode(output int c);
      for (c = 0; c < 60 && clock_mode_o !== MODE_MIDDLE; c++) @(negedge clk_i);
   endtask
   task automatic irq_is(logic e);
      repeat (2) @(negedge clk_i);
      chk("irq", {7'h0, irq_o}, {7'h0, e});
   endtask
   // Expected setup and hold half time
   function automatic logic [7:0] half(logic [7:0] x);
      return 8'((6'(x[4:0]) + 6'h1) >> 1);
   endfunction
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Hang guard, well past the expected run
   initial begin
      #(25 * 20000);
      errors++;
      end_sim();
   end
   initial begin
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      foreach (ra[i]) begin
         rd(ra[i], d);
         chk("reset", d, rv[i]);
      end
      $display("reset values done");
      // Random traffic; start bit is refused in middle speed
      repeat (16) begin
         d = 8'($random(seed));
         wr(ADDR_MISC_CLOCK, d);
         rd(ADDR_MISC_CLOCK, v);
         chk("misc", v, d & 8'h07);
         wr(ADDR_START_STOP, d);
         rd(ADDR_START_STOP, v);
         chk("cond", v, d & 8'h7f);
         chk("release", 8'(release_cycles_o), 8'(d[4:0]) + 8'h1);
         chk("setup", 8'(setup_hold_half_o), half(d));
         wr(ADDR_IRQ_ENABLE, d);
         rd(ADDR_IRQ_ENABLE, v);
         chk("irq en", irq_enable_o, d);
      end
      wr(ADDR_IRQ_ENABLE, 8'hdd);
      rd(ADDR_IRQ_ENABLE, v);
      chk("irq en fixed", v, 8'hdd);
      $display("register traffic done");
      // Stop release with and without reload
      for (int b = 0; b < 2; b++) begin
         wr(ADDR_MISC_CLOCK, 8'(b));
         wr(ADDR_EVT_MASK, 8'h02);
         stop_release_ext_i <= 1'b1;
         @(posedge clk_i);
         stop_release_ext_i <= 1'b0;
         @(negedge clk_i);
         chk("reload", {7'h0, reload_o}, 8'(b == 0));
         chk("prescaler", reload_prescaler_o, RELOAD_PRESCALER);
         irq_is(b == 0);
         wr(ADDR_EVT_STATUS, 8'hff);
         irq_is(1'b0);
      end
      $display("stop release done");
      // Program start, short then long wait, event masked first
      for (int w = 0; w < 2; w++) begin
         wr(ADDR_MISC_CLOCK, 8'(w << 2));
         wr(ADDR_CPU_MODE, 8'hc0);
         wr(ADDR_EVT_MASK, 8'h00);
         // Both pins toggle, so some edge matches; switching is off
         scl_pin_i <= 1'b0;
         sda_pin_i <= 1'b0;
         repeat (20) @(posedge clk_i);
         scl_pin_i <= 1'b1;
         sda_pin_i <= 1'b1;
         repeat (20) @(posedge clk_i);
         @(negedge clk_i);
         chk("no start", {6'h0, clock_mode_o}, {6'h0, MODE_LOW});
         wr(ADDR_MISC_CLOCK, 8'(w << 2) | 8'h08);
         wait_mode(n);
         lo = 4 * (w ? WAIT_LONG_CYC : WAIT_SHORT_CYC);
         chk("wait", 8'(n >= lo && n <= lo + 4), 8'h1);
         rd(ADDR_CPU_MODE, d);
         chk("cpu mode", {6'h0, d[7:6]}, {6'h0, MODE_MIDDLE});
         irq_is(1'b0);
         wr(ADDR_EVT_MASK, 8'h01);
         irq_is(1'b1);
         wr(ADDR_EVT_STATUS, 8'h01);
         irq_is(1'b0);
      end
      $display("program switch done");
      // Pin edge: unselected pin ignored, selected pin switches
      for (int k = 0; k < 4; k++) begin
         q = k[0];
         @(posedge clk_i);
         scl_pin_i <= !q;
         sda_pin_i <= !q;
         wr(ADDR_START_STOP, 8'(k << 5));
         wr(ADDR_MISC_CLOCK, 8'h02);
         wr(ADDR_CPU_MODE, 8'hc0);
         if (k[1]) sda_pin_i <= q;
         else scl_pin_i <= q;
         repeat (40) @(negedge clk_i);
         chk("other pin", {6'h0, clock_mode_o}, {6'h0, MODE_LOW});
         @(posedge clk_i);
         if (k[1]) scl_pin_i <= q;
         else sda_pin_i <= q;
         wait_mode(n);
         chk("pin wait", 8'(n >= 20 && n <= 32), 8'h1);
      end
      $display("pin switch done");
      end_sim();
   end
endmodule
bind middle_speed_auto_switch switch_props props (.*);
